// ==== core/irrx_receiver.sv ====
// Purpose: Infrared pulse-distance receiver with Wishbone register access.
// Assumes: ir_input_pin is synchronous to core_clk; 32-bit classic bus.
// Notes:   One-cycle registered ack; unmapped words read zero.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Enable bit low keeps reception stopped.
// - Soft reset bit clears the receive sequencer.
// - Polarity bit inverts the infrared input.
// - Bit order selects LSB or MSB first.
// - Repeat code stops reception unless allowed.
// - Reference field picks full, half, quarter, subclock.
// - Format 00 stores four bytes per frame.
// - Format 01 stores address and command only.
// - Receive data port read-only, resets zero.
// - Header high thresholds are 16-bit registers.
// - Repeat low maximum is 8-bit read-write.
// - Data-full flag tracks stored unread bytes.
// - Event flags clear by read-1 then write-0.
module irrx_receiver
  import irrx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [17:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        ir_input_pin,
  output logic             irq
);

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  irrx_ctrl1_t ctrl1;
  irrx_ctrl2_t ctrl2;
  irrx_state_t state;
  logic [7:0]  irqEnable;
  logic [7:0]  bitRate;
  logic [15:0] header_high_min;
  logic [15:0] header_high_max;
  logic [7:0]  header_low_min;
  logic [7:0]  header_low_max;
  logic [7:0]  d0Min;
  logic [7:0]  d0Max;
  logic [7:0]  d1Min;
  logic [7:0]  d1Max;
  logic [7:0]  rpMin;
  logic [7:0]  rpMax;
  logic [5:0]  flags;
  logic [5:0]  flagsSeen;
  logic        busy;
  logic [7:0]  fifoMem [FIFO_DEPTH];
  logic [4:0]  wrPtr;
  logic [4:0]  rdPtr;
  logic [4:0]  fifoCount;
  logic [1:0]  divCnt;
  logic [7:0]  subCnt;
  logic [15:0] periodCnt;
  logic [5:0]  bitCnt;
  logic [7:0]  shiftReg;
  logic        prevLevel;

  function automatic logic inRange(input logic [15:0] val,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    inRange = (val >= lo) && (val <= hi);
  endfunction

  function automatic logic [4:0] ptrNext(input logic [4:0] ptr);
    ptrNext = (ptr == FIFO_LAST) ? 5'h00 : ptr + 5'h01;
  endfunction

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire        access   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wrAcc    = access & wb_we_i;
  wire        rdAcc    = access & ~wb_we_i;
  wire [15:0] idx      = wb_adr_i[17:2];
  wire        lane0    = wb_sel_i[0];
  wire        lane1    = wb_sel_i[1];
  wire [7:0]  wByte    = wb_dat_i[7:0];
  wire        wrCtrl1  = wrAcc & lane0 & (idx == IDX_CTRL1);
  wire        wrCtrl2  = wrAcc & lane0 & (idx == IDX_CTRL2);
  wire        wrStatus = wrAcc & lane0 & (idx == IDX_STATUS);
  wire        wrIrqClr = wrAcc & lane0 & (idx == IDX_IRQ_CLR);
  wire        rdStatus = rdAcc & (idx == IDX_STATUS);
  wire        rdData   = rdAcc & (idx == IDX_RXDATA);
  wire        fifoEmpty = (fifoCount == 5'h00);
  wire        fifoFull  = (fifoCount == FIFO_LAST + 5'h01);
  wire        pop       = rdData & ~fifoEmpty;
  wire [7:0]  statusVal = {busy, ~fifoEmpty, flags};

  // Read mux; the data port reads zero while empty
  logic [15:0] readVal;
  always_comb begin
    unique case (idx)
      IDX_CTRL1:   readVal = {8'h00, ctrl1};
      IDX_CTRL2:   readVal = {8'h00, ctrl2};
      IDX_STATUS:  readVal = {8'h00, statusVal};
      IDX_IRQ_EN:  readVal = {8'h00, irqEnable};
      IDX_BITRATE: readVal = {8'h00, bitRate};
      IDX_RXDATA:  readVal = fifoEmpty ? 16'h0000 : {8'h00, fifoMem[rdPtr]};
      IDX_HH_MIN:  readVal = header_high_min;
      IDX_HH_MAX:  readVal = header_high_max;
      IDX_HL_MIN:  readVal = {8'h00, header_low_min};
      IDX_HL_MAX:  readVal = {8'h00, header_low_max};
      IDX_D0_MIN:  readVal = {8'h00, d0Min};
      IDX_D0_MAX:  readVal = {8'h00, d0Max};
      IDX_D1_MIN:  readVal = {8'h00, d1Min};
      IDX_D1_MAX:  readVal = {8'h00, d1Max};
      IDX_RP_MIN:  readVal = {8'h00, rpMin};
      IDX_RP_MAX:  readVal = {8'h00, rpMax};
      default:     readVal = 16'h0000;
    endcase
  end

  // Registered ack, one cycle after the request is seen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= access;
      if (rdAcc) begin
        wb_dat_o <= {16'h0000, readVal};
      end
    end
  end

  // ------------------------------------------------------------------
  // Sampling clock and input conditioning
  // ------------------------------------------------------------------
  wire rxRun   = ctrl1.irRxEnable & ~ctrl1.sequencerSoftReset;
  wire subTick = (subCnt == bitRate);
  wire irLevel = ir_input_pin ^ ctrl1.inputInvert;
  logic tick;
  always_comb begin
    unique case (ctrl1.refClockSelect)
      REF_CLK_FULL: tick = 1'b1;
      REF_CLK_HALF: tick = divCnt[0];
      REF_CLK_QTR:  tick = (divCnt == 2'b11);
      REF_CLK_SUB:  tick = subTick;
    endcase
  end

  // Free dividers; subclock period is the bit rate divisor plus one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt <= 2'b00;
      subCnt <= 8'h00;
    end else begin
      divCnt <= divCnt + 2'b01;
      subCnt <= subTick ? 8'h00 : subCnt + 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // Period classification
  // ------------------------------------------------------------------
  wire rise    = tick & irLevel & ~prevLevel;
  wire fall    = tick & ~irLevel & prevLevel;
  wire hdrHiOk = inRange(periodCnt, header_high_min, header_high_max);
  wire hdrLoOk = inRange(periodCnt, {8'h00, header_low_min}, {8'h00, header_low_max});
  wire rptOk   = inRange(periodCnt, {8'h00, rpMin}, {8'h00, rpMax});
  wire zeroOk  = inRange(periodCnt, {8'h00, d0Min}, {8'h00, d0Max});
  wire oneOk   = inRange(periodCnt, {8'h00, d1Min}, {8'h00, d1Max});
  wire [7:0] dMax  = (d0Max > d1Max) ? d0Max : d1Max;
  // A low too long to be any data bit is a framing error inside the frame
  wire lowTooLong = (state == S_BIT_LOW) & (periodCnt > {8'h00, dMax});
  wire bitDone = (state == S_BIT_LOW) & rise & (zeroOk | oneOk);
  wire bitVal  = oneOk & ~zeroOk;
  wire [7:0] nextShift = ctrl1.msbFirstSelect ?
                         {shiftReg[6:0], bitVal} :
                         {bitVal, shiftReg[7:1]};
  wire byteDone = bitDone & (bitCnt[2:0] == 3'b111);
  wire [1:0] byteIdx = bitCnt[4:3];
  wire keepByte = (ctrl2.frameFormat == FMT_FOUR_BYTES) |
                  ~byteIdx[0];
  // Gated by run so a byte finishing as enable drops is not stored
  wire push     = byteDone & keepByte & rxRun;
  wire isRepeat = (state == S_HDR_LOW) & rise & ~hdrLoOk & rptOk;
  wire isHeader = (state == S_HDR_LOW) & rise & hdrLoOk;
  wire isStop   = (state == S_BIT_HIGH) & fall & (bitCnt == BITS_FRAME);
  wire isAbort  = ((state == S_HDR_HIGH) & fall & ~hdrHiOk) |
                  ((state == S_HDR_LOW) & rise & ~hdrLoOk & ~rptOk) |
                  ((state == S_BIT_LOW) & rise & ~zeroOk & ~oneOk);
  wire isFrame  = lowTooLong & tick;

  // Receive sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n || !rxRun) begin
      state     <= S_IDLE;
      periodCnt <= 16'h0000;
      bitCnt    <= 6'h00;
      shiftReg  <= 8'h00;
      prevLevel <= 1'b0;
      busy      <= 1'b0;
    end else if (tick) begin
      prevLevel <= irLevel;
      periodCnt <= (rise | fall) ? 16'h0001 :
                   (&periodCnt ? periodCnt : periodCnt + 16'h0001);
      unique case (state)
        S_IDLE: begin
          if (rise) begin
            state <= S_HDR_HIGH;
          end
        end
        S_HDR_HIGH: begin
          if (fall) begin
            state <= hdrHiOk ? S_HDR_LOW : S_IDLE;
          end
        end
        S_HDR_LOW: begin
          if (rise) begin
            state  <= isHeader ? S_BIT_HIGH : S_IDLE;
            busy   <= isHeader;
            bitCnt <= 6'h00;
          end
        end
        S_BIT_HIGH: begin
          if (fall) begin
            state <= isStop ? S_IDLE : S_BIT_LOW;
            busy  <= ~isStop;
          end
        end
        S_BIT_LOW: begin
          if (lowTooLong) begin
            state <= S_IDLE;
            busy  <= 1'b0;
          end else if (rise) begin
            state    <= bitDone ? S_BIT_HIGH : S_IDLE;
            busy     <= bitDone;
            bitCnt   <= bitCnt + 6'h01;
            shiftReg <= nextShift;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Receive FIFO
  // ------------------------------------------------------------------
  // Overrun drops the new byte so older bytes stay intact
  wire doPush = push & ~fifoFull;
  always_ff @(posedge core_clk) begin
    if (!rst_n || ctrl1.sequencerSoftReset) begin
      wrPtr     <= 5'h00;
      rdPtr     <= 5'h00;
      fifoCount <= 5'h00;
    end else begin
      if (doPush) begin
        wrPtr <= ptrNext(wrPtr);
      end
      if (pop) begin
        rdPtr <= ptrNext(rdPtr);
      end
      fifoCount <= fifoCount + {4'h0, doPush} - {4'h0, pop};
    end
  end

  // Storage write; reset leaves words zero so stale reads are defined
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifoMem[i] <= RST_BYTE;
      end
    end else if (doPush) begin
      fifoMem[wrPtr] <= nextShift;
    end
  end

  // ------------------------------------------------------------------
  // Event flags and interrupt
  // ------------------------------------------------------------------
  logic [5:0] events;
  always_comb begin
    events              = 6'h00;
    events[EV_REPEAT]   = isRepeat & tick & rxRun;
    events[EV_OVERRUN]  = push & fifoFull & tick & rxRun;
    events[EV_END]      = isStop & tick & rxRun;
    events[EV_ABORT]    = isAbort & tick & rxRun;
    events[EV_FRAMING]  = isFrame & rxRun;
    events[EV_HEADER]   = isHeader & tick & rxRun;
  end
  // Status write clears bits seen as one and now written zero; the clear register clears bits written one
  wire [5:0] swClear = (wrStatus ? (flagsSeen & ~wByte[5:0]) : 6'h00) |
                       (wrIrqClr ? wByte[5:0] : 6'h00);

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags     <= 6'h00;
      flagsSeen <= 6'h00;
    end else begin
      flags <= (flags & ~swClear) | events;
      if (rdStatus) begin
        flagsSeen <= flags;
      end else if (wrStatus) begin
        flagsSeen <= 6'h00;
      end
    end
  end

  assign irq = |(flags & irqEnable[5:0]);

  // ------------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl1     <= irrx_ctrl1_t'(RST_BYTE);
      ctrl2     <= irrx_ctrl2_t'(RST_BYTE);
      irqEnable <= RST_BYTE;
      bitRate   <= RST_BITRATE;
    end else begin
      if (wrCtrl1) begin
        ctrl1 <= irrx_ctrl1_t'(wByte);
      end else if (events[EV_REPEAT] && !ctrl1.rxAfterRepeatEnable) begin
        ctrl1.irRxEnable <= 1'b0;
      end
      if (wrCtrl2) begin
        ctrl2 <= irrx_ctrl2_t'(wByte);
      end
      if (wrAcc && lane0 && idx == IDX_IRQ_EN) begin
        irqEnable <= wByte;
      end
      if (wrAcc && lane0 && idx == IDX_BITRATE) begin
        bitRate <= wByte;
      end
    end
  end

  // Threshold registers; 16-bit ones take both low byte lanes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      header_high_min <= RST_WORD;
      header_high_max <= RST_WORD;
      {header_low_min, header_low_max, d0Min, d0Max} <= {4{RST_BYTE}};
      {d1Min, d1Max, rpMin, rpMax} <= {4{RST_BYTE}};
    end else if (wrAcc) begin
      if (idx == IDX_HH_MIN && lane0) header_high_min[7:0]  <= wByte;
      if (idx == IDX_HH_MIN && lane1) header_high_min[15:8] <= wb_dat_i[15:8];
      if (idx == IDX_HH_MAX && lane0) header_high_max[7:0]  <= wByte;
      if (idx == IDX_HH_MAX && lane1) header_high_max[15:8] <= wb_dat_i[15:8];
      if (idx == IDX_HL_MIN && lane0) header_low_min <= wByte;
      if (idx == IDX_HL_MAX && lane0) header_low_max <= wByte;
      if (idx == IDX_D0_MIN && lane0) d0Min <= wByte;
      if (idx == IDX_D0_MAX && lane0) d0Max <= wByte;
      if (idx == IDX_D1_MIN && lane0) d1Min <= wByte;
      if (idx == IDX_D1_MAX && lane0) d1Max <= wByte;
      if (idx == IDX_RP_MIN && lane0) rpMin <= wByte;
      if (idx == IDX_RP_MAX && lane0) rpMax <= wByte;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_disabled_idle;
    !ctrl1.irRxEnable |=> (state == S_IDLE) && !busy;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle)
    else $error("sequencer active while disabled");

  property p_soft_reset;
    ctrl1.sequencerSoftReset |=> (state == S_IDLE) && (fifoCount == 5'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not clear sequencer");

  property p_invert;
    rxRun && tick && (state == S_IDLE) && !prevLevel &&
    (ir_input_pin != ctrl1.inputInvert) |=> state == S_HDR_HIGH;
  endproperty
  a_invert: assert property (p_invert)
    else $error("polarity not applied to input");

  property p_bit_order;
    bitDone && tick && rxRun |=>
      (ctrl1.msbFirstSelect ? shiftReg[0] : shiftReg[7]) == $past(bitVal);
  endproperty
  a_bit_order: assert property (p_bit_order)
    else $error("received bit in wrong position");

  property p_repeat_stop;
    events[EV_REPEAT] && !ctrl1.rxAfterRepeatEnable && !wrCtrl1
      |=> !ctrl1.irRxEnable;
  endproperty
  a_repeat_stop: assert property (p_repeat_stop)
    else $error("reception kept after repeat");

  sequence s_qtr_tick;
    // A switch away from quarter rate may bring a tick early
    tick ##1 (!tick || (ctrl1.refClockSelect != REF_CLK_QTR)) [*3];
  endsequence
  property p_quarter;
    (ctrl1.refClockSelect == REF_CLK_QTR) && tick && !wrCtrl1
      |-> s_qtr_tick;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("quarter rate tick spacing wrong");

  property p_two_byte;
    byteDone && byteIdx[0] && rxRun && !pop &&
    (ctrl2.frameFormat == FMT_TWO_BYTES) |=> fifoCount == $past(fifoCount);
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("two byte mode stored an odd byte");

  property p_full_flag;
    doPush && tick && rxRun && !pop |=> statusVal[ST_FULL];
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("full flag not set after store");

  property p_pop;
    pop && !doPush |=> fifoCount == $past(fifoCount) - 5'h01;
  endproperty
  a_pop: assert property (p_pop)
    else $error("data port read did not advance");

  property p_write_one;
    wrStatus && (wByte[5:0] == 6'h3F) && !wrIrqClr
      |=> ($past(flags) & ~flags) == 6'h00;
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("writing one changed an event flag");

  property p_header;
    isHeader && tick && rxRun |=> (state == S_BIT_HIGH) && flags[EV_HEADER];
  endproperty
  a_header: assert property (p_header)
    else $error("header period not accepted");

endmodule

`default_nettype wire

// ==== core/irrx_pkg.sv ====
// Purpose: Shared constants and types for the infrared remote receiver.
// Assumes: Register indexes are word indexes; byte address is index * 4.
// Notes:   Control words travel as packed structs.
package irrx_pkg;

  // ------------------------------------------------------------------
  // Register indexes
  // ------------------------------------------------------------------
  localparam logic [15:0] IDX_CTRL1    = 16'hFA40;
  localparam logic [15:0] IDX_CTRL2    = 16'hFA41;
  localparam logic [15:0] IDX_STATUS   = 16'hFA42;
  localparam logic [15:0] IDX_IRQ_EN   = 16'hFA43;
  localparam logic [15:0] IDX_BITRATE  = 16'hFA44;
  localparam logic [15:0] IDX_RXDATA   = 16'hFA45;
  localparam logic [15:0] IDX_HH_MIN   = 16'hFA46;
  localparam logic [15:0] IDX_HH_MAX   = 16'hFA48;
  localparam logic [15:0] IDX_HL_MIN   = 16'hFA4A;
  localparam logic [15:0] IDX_HL_MAX   = 16'hFA4B;
  localparam logic [15:0] IDX_D0_MIN   = 16'hFA4C;
  localparam logic [15:0] IDX_D0_MAX   = 16'hFA4D;
  localparam logic [15:0] IDX_D1_MIN   = 16'hFA4E;
  localparam logic [15:0] IDX_D1_MAX   = 16'hFA4F;
  localparam logic [15:0] IDX_RP_MIN   = 16'hFA50;
  localparam logic [15:0] IDX_RP_MAX   = 16'hFA51;
  localparam logic [15:0] IDX_IRQ_CLR  = 16'hFA52;

  // ------------------------------------------------------------------
  // Reset values, sizes, field positions
  // ------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [7:0]  RST_BITRATE  = 8'hFF;
  localparam int          FIFO_DEPTH   = 18;
  localparam logic [4:0]  FIFO_LAST    = 5'h11;
  localparam logic [5:0]  BITS_FRAME   = 6'h20;
  localparam int          ST_BUSY      = 7;
  localparam int          ST_FULL      = 6;
  localparam int          EV_REPEAT    = 5;
  localparam int          EV_OVERRUN   = 4;
  localparam int          EV_END       = 3;
  localparam int          EV_ABORT     = 2;
  localparam int          EV_FRAMING   = 1;
  localparam int          EV_HEADER    = 0;

  typedef enum logic [1:0] {
    REF_CLK_FULL = 2'b00,
    REF_CLK_HALF = 2'b01,
    REF_CLK_QTR  = 2'b10,
    REF_CLK_SUB  = 2'b11
  } irrx_refclk_t;

  typedef enum logic [1:0] {
    FMT_FOUR_BYTES = 2'b00,
    FMT_TWO_BYTES  = 2'b01
  } irrx_format_t;

  typedef struct packed {
    logic         irRxEnable;
    logic         sequencerSoftReset;
    logic         inputInvert;
    logic         msbFirstSelect;
    logic         rxAfterRepeatEnable;
    logic         reserved;
    irrx_refclk_t refClockSelect;
  } irrx_ctrl1_t;

  typedef struct packed {
    logic [1:0] frameFormat;
    logic [5:0] reserved;
  } irrx_ctrl2_t;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_HDR_HIGH = 3'b001,
    S_HDR_LOW  = 3'b010,
    S_BIT_HIGH = 3'b011,
    S_BIT_LOW  = 3'b100
  } irrx_state_t;

endpackage

// ==== sim/irrx_ir_source.sv ====
// Purpose: Behavioural infrared sender driving the receiver input pin.
// Assumes: Line idles as space; one tick lasts s core_clk cycles.
// Notes:   Called from the bench just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none

module irrx_ir_source (
  input  wire logic core_clk,
  output logic      pin
);
  logic inv;

  // Idle space at time zero so no false header is seen
  initial begin
    inv = 1'b0;
    pin = 1'b0;
  end

  // ------------------------------------------------------------------
  // Line levels
  // ------------------------------------------------------------------
  // Hold one level for n ticks; polarity flip models inverted optics
  task automatic level(input logic v, input int n, input int s);
    pin <= v ^ inv;
    repeat (n * s) @(posedge core_clk);
  endtask

  // Header, 32 bits first bit from w[0] or a repeat space if rep, stop mark, long space
  task automatic frame(input logic [31:0] w, input int s, input logic rep);
    level(1'b1, 5, s);
    if (rep) begin
      level(1'b0, 6, s);
    end else begin
      level(1'b0, 3, s);
      for (int i = 0; i < 32; i++) begin
        level(1'b1, 1, s);
        level(1'b0, w[i] ? 3 : 1, s);
      end
    end
    level(1'b1, 1, s);
    level(1'b0, 8, s);
  endtask
endmodule

`default_nettype wire

// ==== sim/test_irrx_receiver.sv ====
// Purpose: Self-checking bench for the infrared receiver block.
// Assumes: One-cycle Wishbone ack; thresholds as in the walk example.
// Notes:   Reads note expectations in a queue; a monitor compares them.
`timescale 1ns/100ps
`default_nettype none

module test_irrx_receiver;
  import irrx_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic [56:0] req;
  logic        wbCyc, wbStb, wbWe;
  logic [3:0]  wbSel;
  logic [17:0] wbAdr;
  logic [31:0] wbDatW, wbDatR, rnd;
  logic        wbAck, irPin, irq;
  logic [63:0] expQ[$];
  logic [63:0] e;
  int          errors, checked;
  // Thresholds in write order: hh, hl, zero, one, repeat min/max
  localparam logic [79:0] THR_TAB = 80'h07_06_04_03_02_01_04_02_06_04;

  assign {wbCyc, wbStb, wbWe, wbSel, wbAdr, wbDatW} = req;

  irrx_receiver irrx_receiver_i (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
    .wb_ack_o(wbAck), .ir_input_pin(irPin), .irq(irq));
  irrx_ir_source src_i (.core_clk(core_clk), .pin(irPin));

  // ------------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------------
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    errors++;
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) fail(got, exp);
  endtask

  task automatic summarize;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Single classic cycle; a lost ack ends the run
  task automatic bus(input logic [15:0] idx, input logic we,
                     input logic [31:0] d, input logic [31:0] m);
    int n;
    @(posedge core_clk);
    if (!we) expQ.push_back({m, d});
    req <= {3'b110 | {2'b0, we}, 4'hF, idx, 2'b00, we ? d : 32'h0};
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (wbAck) break;
    end
    req <= 57'h0;
    if (n == 50) begin
      fail(32'h0, 32'h1);
      summarize();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d, 32'h0);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] d,
                    input logic [31:0] m);
    bus(idx, 1'b0, d & m, m);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Byte b of the last payload as the block should assemble it
  function automatic logic [31:0] byteOf(input int b, input logic msb);
    logic [7:0] v;
    v = rnd[8*b +: 8];
    if (msb) v = {<<{v}};
    return {24'h0, v};
  endfunction

  // Quiet the receiver, set line polarity, then configure and send
  task automatic send(input logic [7:0] c1, input logic [7:0] c2,
                      input int s, input logic inv, input logic rep);
    rnd = xs(rnd);
    wr(IDX_CTRL1, 32'h0);
    src_i.inv = inv;
    src_i.level(1'b0, 2, 1);
    wr(IDX_CTRL2, {24'h0, c2});
    wr(IDX_CTRL1, {24'h0, c1});
    src_i.frame(rnd, s, rep);
  endtask

  // Every read answer is matched against the oldest note
  always @(posedge core_clk) begin
    if (wbAck && !wbWe) begin
      if (expQ.size() == 0) fail(wbDatR, 32'h0);
      else begin
        e = expQ.pop_front();
        check(wbDatR & e[63:32], e[31:0]);
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    rnd = 32'h8249;
    req = 57'h0;
    rst_n = 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // Module stop is assumed released before the first access
    for (int a = 16'hFA40; a <= 16'hFA51; a++)
      rd(a[15:0], a == 16'hFA44 ? 32'hFF : 32'h0, '1);
    wr(IDX_HH_MIN, 32'h1234ABCD);
    rd(IDX_HH_MIN, 32'hABCD, '1);
    wr(IDX_RXDATA, 32'h55);
    rd(IDX_RXDATA, 32'h0, '1);
    wr(16'hFA47, 32'h77);
    rd(16'hFA47, 32'h0, '1);
    // Thresholds: header 4..6 / 2..4, zero 1..2, one 3..4, repeat 6..7
    for (int i = 0; i < 10; i++)
      wr(i < 2 ? 16'hFA46 + 16'(2 * i) : 16'hFA48 + 16'(i),
         {24'h0, THR_TAB[8 * i +: 8]});
    rd(IDX_RP_MAX, 32'h7, '1);
    wr(IDX_BITRATE, 32'h1);
    // Each sampling clock, four bytes LSB first
    for (int r = 0; r < 4; r++) begin
      send(8'h80 | 8'(r), 8'h00, r == 3 ? 2 : 1 << r, 1'b0, 1'b0);
      rd(IDX_STATUS, 32'h49, 32'hC9);
      for (int b = 0; b < 4; b++) rd(IDX_RXDATA, byteOf(b, 0), '1);
      rd(IDX_STATUS, 32'h0, 32'h40);
    end
    // Inverted line, MSB first, two-byte format
    send(8'hB0, 8'h40, 1, 1'b1, 1'b0);
    rd(IDX_RXDATA, byteOf(0, 1), '1);
    rd(IDX_RXDATA, byteOf(2, 1), '1);
    rd(IDX_RXDATA, 32'h0, '1);
    // Disabled, then held in soft reset: nothing stored
    send(8'h00, 8'h00, 1, 1'b0, 1'b0);
    rd(IDX_STATUS, 32'h0, 32'h40);
    send(8'hC0, 8'h00, 1, 1'b0, 1'b0);
    rd(IDX_RXDATA, 32'h0, '1);
    // Repeat code, with and without reception afterwards
    for (int k = 0; k < 2; k++) begin
      send(k ? 8'h88 : 8'h80, 8'h00, 1, 1'b0, 1'b1);
      rd(IDX_STATUS, 32'h20, 32'h20);
      rd(IDX_CTRL1, k ? 32'h88 : 32'h0, '1);
    end
    // Five unread frames overflow the store; clear register, soft reset
    for (int f = 0; f < 5; f++) send(8'h80, 8'h00, 1, 1'b0, 1'b0);
    rd(IDX_STATUS, 32'h50, 32'h50);
    wr(IDX_IRQ_CLR, 32'h10);
    rd(IDX_STATUS, 32'h40, 32'h50);
    wr(IDX_CTRL1, 32'h40);
    rd(IDX_STATUS, 32'h0, 32'h40);
    // Interrupt masked, raised, write-1 ignored, read-then-zero clears
    @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_EN, 32'h08);
    @(negedge core_clk);
    check({31'h0, irq}, 32'h1);
    wr(IDX_STATUS, 32'hFF);
    rd(IDX_STATUS, 32'h29, 32'h29);
    wr(IDX_STATUS, 32'h00);
    rd(IDX_STATUS, 32'h00, 32'h29);
    @(negedge core_clk);
    check({31'h0, irq}, 32'h0);
    repeat (3) @(posedge core_clk);
    summarize();
  end
endmodule

`default_nettype wire
